// ---- iemr_eeprom.sv ----
// Behavioural two-wire EEPROM that answers one device address
`timescale 1ns/100ps
`default_nettype none
module iemr_eeprom #(
  parameter logic [6:0] DEV = 7'h50
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_pull
);
  logic [7:0] sh;
  logic [7:0] mem;
  logic act, rd, first;
  int k;
  initial begin
    {sh, act, rd, first, sda_pull} = '0;
    mem = 8'h5a;
    k = 0;
  end
  always @(negedge sda) if (scl === 1'b1) begin
    {act, first, rd} = 3'b110;
    k = -1;
  end
  always @(posedge sda) if (scl === 1'b1) act = 1'b0;
  // A master nack on a read byte ends driving, else the stop is blocked
  always @(posedge scl) if (act) begin
    if (k < 8) sh = {sh[6:0], sda};
    else if (rd && !first && sda) act = 1'b0;
  end
  always @(negedge scl) begin
    k = k + 1;
    sda_pull = 1'b0;
    if (act && k == 8 && (first || !rd)) begin
      sda_pull = !first || (sh[7:1] == DEV);
      act = sda_pull;
      if (first) rd = sh[0];
      else mem = sh;
    end
    if (k == 9) begin
      k = 0;
      first = 1'b0;
    end
    if (act && rd && !first && k < 8) sda_pull = !mem[7 - k];
    if (act && rd && !first && k == 7) mem = mem + 8'h11;
  end
endmodule : iemr_eeprom
`default_nettype wire

// ---- iemr_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides, storage in flip-flops
`timescale 1ns/100ps
`default_nettype none
module iemr_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_idx_r;
  logic [AW-1:0] rd_idx_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign in_ready = (count_r != (AW + 1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_idx_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] idx);
    wrap_inc = (idx == AW'(DEPTH - 1)) ? '0 : idx + 1'b1;
  endfunction : wrap_inc

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_idx_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_idx_r <= '0;
      rd_idx_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_idx_r <= wrap_inc(wr_idx_r);
      end
      if (pop) begin
        rd_idx_r <= wrap_inc(rd_idx_r);
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  a_fifo_no_over: assert property (@(posedge clk) disable iff (!reset_n)
    count_r == (AW + 1)'(DEPTH) |-> !in_ready) else $error("fifo accepts while full");
endmodule : iemr_fifo
`default_nettype wire

// ---- iemr_pkg.sv ----
// Package: register map, field positions and link timing for the EEPROM master
package iemr_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] OFS_STATUS = 16'hf0b0;
  localparam logic [15:0] OFS_ADDR = 16'hf0b1;
  localparam logic [15:0] OFS_RXBYTE = 16'hf0b2;
  localparam logic [15:0] OFS_TXBYTE = 16'hf0b3;
  localparam int BIT_STOP = 0;
  localparam int BIT_TXE = 2;
  localparam int BIT_SPEED = 3;
  localparam int BIT_ERR = 5;
  localparam int BIT_RXF = 7;
  localparam logic RST_TXE = 1'b1;
  localparam logic RST_SPEED = 1'b0;
  localparam logic RST_ERR = 1'b0;
  localparam logic RST_RXF = 1'b0;
  localparam logic RST_STOP = 1'b0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // ****************************************
  // Link timing
  // ****************************************
  localparam int LINK_PERIOD_NS = 48;
  localparam int RATE_STD_KBPS = 100;
  localparam int RATE_FAST_KBPS = 400;
  localparam int Q_STD_NS = 1000000 / (RATE_STD_KBPS * 4);
  localparam int Q_FAST_NS = 1000000 / (RATE_FAST_KBPS * 4);
  localparam logic [7:0] Q_STD_CYC = 8'((Q_STD_NS / LINK_PERIOD_NS) < 1 ? 1 : Q_STD_NS / LINK_PERIOD_NS);
  localparam logic [7:0] Q_FAST_CYC = 8'((Q_FAST_NS / LINK_PERIOD_NS) < 1 ? 1 : Q_FAST_NS / LINK_PERIOD_NS);
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 10;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_SHIFT = 3'b010,
    ST_STOP = 3'b011,
    ST_REPORT = 3'b100
  } iemr_state_t;
endpackage : iemr_pkg

// ---- iemr_top.sv ----
// Two-wire EEPROM master: MCU register file, link engine and crossings
// What this block does
// - With stop bit 0, no stop follows a received byte or an acknowledged sent byte.
// - With stop bit 1, a stop follows the sent or received byte.
// - Writing the transmit byte clears transmitter_empty (status bit 2).
// - transmitter_empty resets to 1, sets when the link engine takes the job from the transmit byte write.
// - Status bit 3 selects 100 or 400 kbps; resets to 0.
// - Error flag bit 5 sets when slave does not acknowledge; resets 0.
// - Writing 1 clears the error flag; writing 0 leaves it.
// - receiver_full bit 7 resets 0, sets when receive byte loads.
// - Reading the receive byte clears receiver_full.
// - Address register: 7-bit slave address bits 7..1, bit 0 direction.
// - Receive byte is read-only, resets 00h, holds last read byte.
// - Writing the transmit byte starts a transfer.
// - A new transfer sends start, address register byte, then the transmit byte, or with bit 0 set receives a byte.
// - Setting transmitter_empty or receiver_full raises an interrupt.
// - Bytes go MSB first in 8 bits, each followed by acknowledge.
`timescale 1ns/100ps
`default_nettype none
module iemr_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic [15:0] mcu_addr,
  input wire logic mcu_wr,
  input wire logic mcu_rd,
  input wire logic [7:0] mcu_wdata,
  output logic [7:0] mcu_rdata,
  output logic mcu_irq,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n
);
  // ****************************************
  // MCU side registers
  // ****************************************
  logic stop_r;
  logic txe_r;
  logic speed_r;
  logic err_r;
  logic rxf_r;
  logic [7:0] addr_r;
  logic [7:0] rxbyte_r;
  logic [7:0] rdata_r;
  logic irq_r;
  logic [7:0] job_addr_r;
  logic [7:0] job_data_r;
  logic job_stop_r;
  logic job_speed_r;
  logic job_need_r;
  logic req_tgl_r;
  logic open_r;
  logic open_dir_r;
  logic wr_status;
  logic wr_addr;
  logic wr_tx;
  logic rd_rx;
  logic auto_rd;
  // Crossing registers, link to MCU, and the ack toggle from MCU to link
  logic taken_m_r;
  logic taken_s_r;
  logic taken_d_r;
  logic done_m_r;
  logic done_s_r;
  logic done_d_r;
  logic ack_tgl_r;
  logic taken_evt;
  logic done_evt;
  // FIFO
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [9:0] fifo_out_data;
  logic fifo_push;
  logic load_rx;
  logic pop_err;
  // Link side
  iemr_pkg::iemr_state_t state_r;
  logic req_m_r;
  logic req_s_r;
  logic req_seen_r;
  logic ack_m_r;
  logic ack_s_r;
  logic ack_seen_r;
  logic sda_m_r;
  logic sda_s_r;
  logic scl_m_r;
  logic scl_s_r;
  logic taken_tgl_r;
  logic done_tgl_r;
  logic [7:0] shreg_r;
  logic [7:0] data_l_r;
  logic [7:0] rx_l_r;
  logic [3:0] bit_r;
  logic [1:0] phase_r;
  logic [7:0] qcnt_r;
  logic stop_l_r;
  logic fast_l_r;
  logic rd_byte_r;
  logic is_addr_r;
  logic is_read_r;
  logic held_r;
  logic lerr_r;
  logic tick;
  logic nack;
  logic scl_lvl;
  logic sda_lvl;
  logic scl_lvl_r;
  logic sda_lvl_r;
  logic sda_hold_r;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  assign wr_status = mcu_wr && hit(mcu_addr, iemr_pkg::OFS_STATUS);
  assign wr_addr = mcu_wr && hit(mcu_addr, iemr_pkg::OFS_ADDR);
  assign wr_tx = mcu_wr && hit(mcu_addr, iemr_pkg::OFS_TXBYTE);
  assign rd_rx = mcu_rd && hit(mcu_addr, iemr_pkg::OFS_RXBYTE);
  // An open read without stop fetches the next byte once the current one is read
  assign auto_rd = rd_rx && open_r && open_dir_r && !wr_tx;
  assign taken_evt = taken_s_r ^ taken_d_r;
  assign done_evt = done_s_r ^ done_d_r;
  assign fifo_push = done_evt && fifo_in_ready;
  // A read byte waits in the FIFO until the receive register is free
  assign fifo_out_ready = !(fifo_out_data[8] && !fifo_out_data[9] && rxf_r);
  assign load_rx = fifo_out_valid && fifo_out_ready && fifo_out_data[8] && !fifo_out_data[9];
  assign pop_err = fifo_out_valid && fifo_out_ready && fifo_out_data[9];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stop_r <= iemr_pkg::RST_STOP;
      speed_r <= iemr_pkg::RST_SPEED;
      addr_r <= iemr_pkg::RST_BYTE;
    end else begin
      if (wr_status) begin
        stop_r <= mcu_wdata[iemr_pkg::BIT_STOP];
        speed_r <= mcu_wdata[iemr_pkg::BIT_SPEED];
      end
      if (wr_addr) begin
        addr_r <= mcu_wdata;
      end
    end
  end

  // ****************************************
  // Handshake flags
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txe_r <= iemr_pkg::RST_TXE;
      rxf_r <= iemr_pkg::RST_RXF;
      err_r <= iemr_pkg::RST_ERR;
      rxbyte_r <= iemr_pkg::RST_BYTE;
    end else begin
      if (taken_evt) begin
        txe_r <= 1'b1;
      end else if (wr_tx) begin
        txe_r <= 1'b0;
      end
      if (load_rx) begin
        rxf_r <= 1'b1;
        rxbyte_r <= fifo_out_data[7:0];
      end else if (rd_rx) begin
        rxf_r <= 1'b0;
      end
      if (pop_err) begin
        err_r <= 1'b1;
      end else if (wr_status && mcu_wdata[iemr_pkg::BIT_ERR]) begin
        err_r <= 1'b0;
      end
    end
  end

  // One-cycle interrupt on each rise of either handshake flag
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (taken_evt && !txe_r) || (load_rx && !rxf_r);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= iemr_pkg::RST_BYTE;
    end else if (mcu_rd) begin
      if (hit(mcu_addr, iemr_pkg::OFS_STATUS)) begin
        rdata_r <= {rxf_r, 1'b0, err_r, 1'b0, speed_r, txe_r, 1'b0, stop_r};
      end else if (hit(mcu_addr, iemr_pkg::OFS_ADDR)) begin
        rdata_r <= addr_r;
      end else if (hit(mcu_addr, iemr_pkg::OFS_RXBYTE)) begin
        rdata_r <= rxbyte_r;
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end

  // ****************************************
  // Job snapshot and request toggle
  // ****************************************
  // Job fields stay still from the toggle until the link has taken them
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      job_addr_r <= iemr_pkg::RST_BYTE;
      job_data_r <= iemr_pkg::RST_BYTE;
      job_stop_r <= 1'b0;
      job_speed_r <= 1'b0;
      job_need_r <= 1'b0;
      req_tgl_r <= 1'b0;
    end else if (wr_tx || auto_rd) begin
      job_addr_r <= wr_tx ? addr_r : job_addr_r;
      job_data_r <= mcu_wdata;
      job_stop_r <= stop_r;
      job_speed_r <= speed_r;
      // Continued write and auto read skip address; any other transmit write re-addresses
      job_need_r <= wr_tx && !(open_r && !open_dir_r && !addr_r[0]);
      req_tgl_r <= !req_tgl_r;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      open_r <= 1'b0;
      open_dir_r <= 1'b0;
    end else if (fifo_push) begin
      open_r <= !job_stop_r && !done_err_bit();
      open_dir_r <= job_addr_r[0];
    end
  end

  function automatic logic done_err_bit();
    done_err_bit = lerr_r;
  endfunction : done_err_bit

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      taken_m_r <= 1'b0;
      taken_s_r <= 1'b0;
      taken_d_r <= 1'b0;
      done_m_r <= 1'b0;
      done_s_r <= 1'b0;
      done_d_r <= 1'b0;
      ack_tgl_r <= 1'b0;
    end else begin
      taken_m_r <= taken_tgl_r;
      taken_s_r <= taken_m_r;
      taken_d_r <= taken_s_r;
      done_m_r <= done_tgl_r;
      done_s_r <= done_m_r;
      // A done event stays pending until the FIFO can take it
      if (!done_evt || fifo_in_ready) begin
        done_d_r <= done_s_r;
      end
      if (fifo_push) begin
        ack_tgl_r <= !ack_tgl_r;
      end
    end
  end

  iemr_fifo #(
    .WIDTH(iemr_pkg::FIFO_WIDTH),
    .DEPTH(iemr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(done_evt),
    .in_ready(fifo_in_ready),
    .in_data({lerr_r, is_read_r, rx_l_r}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  assign mcu_rdata = rdata_r;
  assign mcu_irq = irq_r;

  // ****************************************
  // Link engine
  // ****************************************
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_m_r <= 1'b0;
      req_s_r <= 1'b0;
      ack_m_r <= 1'b0;
      ack_s_r <= 1'b0;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
    end else begin
      req_m_r <= req_tgl_r;
      req_s_r <= req_m_r;
      ack_m_r <= ack_tgl_r;
      ack_s_r <= ack_m_r;
      sda_m_r <= sda_i;
      sda_s_r <= sda_m_r;
      scl_m_r <= scl_i;
      scl_s_r <= scl_m_r;
    end
  end

  // High phase waits for the line to rise, so a stretching slave is honoured
  assign tick = (qcnt_r == 8'h00) && !(phase_r == 2'd2 && !scl_s_r);
  assign nack = sda_s_r;

  // Reload one short: a quarter is the tick cycle plus the count down to zero
  function automatic logic [7:0] quarter_reload(input logic fast);
    quarter_reload = (fast ? iemr_pkg::Q_FAST_CYC : iemr_pkg::Q_STD_CYC) - 8'h01;
  endfunction : quarter_reload

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      qcnt_r <= iemr_pkg::Q_STD_CYC - 8'h01;
    end else if (state_r == iemr_pkg::ST_IDLE || state_r == iemr_pkg::ST_REPORT) begin
      // Idle follows the pending job, so its first quarter already has the new rate
      qcnt_r <= quarter_reload(job_speed_r);
    end else if (tick) begin
      qcnt_r <= quarter_reload(fast_l_r);
    end else if (qcnt_r != 8'h00) begin
      qcnt_r <= qcnt_r - 8'h01;
    end
  end

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= iemr_pkg::ST_IDLE;
      req_seen_r <= 1'b0;
      ack_seen_r <= 1'b0;
      taken_tgl_r <= 1'b0;
      done_tgl_r <= 1'b0;
      shreg_r <= 8'h00;
      data_l_r <= 8'h00;
      rx_l_r <= 8'h00;
      bit_r <= 4'h0;
      phase_r <= 2'd0;
      stop_l_r <= 1'b0;
      fast_l_r <= 1'b0;
      rd_byte_r <= 1'b0;
      is_addr_r <= 1'b0;
      is_read_r <= 1'b0;
      held_r <= 1'b0;
      lerr_r <= 1'b0;
    end else begin
      unique case (state_r)
        iemr_pkg::ST_IDLE: begin
          if (req_s_r != req_seen_r) begin
            req_seen_r <= req_s_r;
            taken_tgl_r <= !taken_tgl_r;
            stop_l_r <= job_stop_r;
            fast_l_r <= job_speed_r;
            data_l_r <= job_data_r;
            is_read_r <= job_addr_r[0];
            lerr_r <= 1'b0;
            phase_r <= 2'd0;
            bit_r <= 4'h0;
            is_addr_r <= job_need_r;
            rd_byte_r <= !job_need_r && job_addr_r[0];
            shreg_r <= job_need_r ? job_addr_r : (job_addr_r[0] ? 8'hff : job_data_r);
            state_r <= job_need_r ? iemr_pkg::ST_START : iemr_pkg::ST_SHIFT;
          end
        end
        iemr_pkg::ST_START: begin
          if (tick) begin
            phase_r <= phase_r + 2'd1;
            if (phase_r == 2'd3) begin
              state_r <= iemr_pkg::ST_SHIFT;
            end
          end
        end
        iemr_pkg::ST_SHIFT: begin
          if (tick) begin
            phase_r <= phase_r + 2'd1;
            if (phase_r == 2'd3) begin
              if (bit_r != iemr_pkg::ACK_BIT) begin
                shreg_r <= {shreg_r[6:0], sda_s_r};
                bit_r <= bit_r + 4'h1;
              end else if (is_addr_r) begin
                bit_r <= 4'h0;
                is_addr_r <= 1'b0;
                if (nack) begin
                  lerr_r <= 1'b1;
                  state_r <= iemr_pkg::ST_STOP;
                end else begin
                  rd_byte_r <= is_read_r;
                  shreg_r <= is_read_r ? 8'hff : data_l_r;
                end
              end else begin
                rx_l_r <= shreg_r;
                lerr_r <= nack && !rd_byte_r;
                if (stop_l_r || (nack && !rd_byte_r)) begin
                  state_r <= iemr_pkg::ST_STOP;
                end else begin
                  held_r <= 1'b1;
                  done_tgl_r <= !done_tgl_r;
                  state_r <= iemr_pkg::ST_REPORT;
                end
              end
            end
          end
        end
        iemr_pkg::ST_STOP: begin
          if (tick) begin
            phase_r <= phase_r + 2'd1;
            if (phase_r == 2'd3) begin
              held_r <= 1'b0;
              done_tgl_r <= !done_tgl_r;
              state_r <= iemr_pkg::ST_REPORT;
            end
          end
        end
        iemr_pkg::ST_REPORT: begin
          // Next job only after the MCU side has queued this one
          if (ack_s_r != ack_seen_r) begin
            ack_seen_r <= ack_s_r;
            state_r <= iemr_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= iemr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Line levels per state and quarter; 0 means pull low
  always_comb begin
    scl_lvl = 1'b1;
    sda_lvl = 1'b1;
    unique case (state_r)
      iemr_pkg::ST_START: begin
        scl_lvl = (phase_r == 2'd0) ? !held_r : (phase_r != 2'd3);
        sda_lvl = (phase_r < 2'd2);
      end
      iemr_pkg::ST_SHIFT: begin
        scl_lvl = phase_r[1];
        if (bit_r != iemr_pkg::ACK_BIT) begin
          sda_lvl = rd_byte_r ? 1'b1 : shreg_r[7];
        end else begin
          sda_lvl = rd_byte_r ? stop_l_r : 1'b1;
        end
      end
      iemr_pkg::ST_STOP: begin
        scl_lvl = (phase_r != 2'd0);
        sda_lvl = phase_r[1];
      end
      default: begin
        scl_lvl = !held_r;
        sda_lvl = 1'b1;
      end
    endcase
  end

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_lvl_r <= 1'b1;
      sda_lvl_r <= 1'b1;
      sda_hold_r <= 1'b1;
    end else begin
      scl_lvl_r <= scl_lvl;
      sda_lvl_r <= sda_lvl;
      // Data moves one cycle after the clock edge, so a falling clock never makes a false start or stop
      sda_hold_r <= sda_lvl_r;
    end
  end

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n = scl_lvl_r;
  assign sda_oe_n = sda_hold_r;

  // ****************************************
  // Checks
  // ****************************************
  a_txe_wr_clear: assert property (@(posedge clk) disable iff (!reset_n)
    wr_tx && !taken_evt |=> !txe_r) else $error("txe not cleared by write");
  a_txe_take_set: assert property (@(posedge clk) disable iff (!reset_n)
    taken_evt |=> txe_r) else $error("txe not set on take");
  a_rxf_rd_clear: assert property (@(posedge clk) disable iff (!reset_n)
    rd_rx && !load_rx |=> !rxf_r) else $error("rxf not cleared by read");
  a_rx_load_data: assert property (@(posedge clk) disable iff (!reset_n)
    load_rx |=> rxf_r && rxbyte_r == $past(fifo_out_data[7:0])) else $error("rx load wrong");
  a_err_w1c: assert property (@(posedge clk) disable iff (!reset_n)
    wr_status && mcu_wdata[5] && !pop_err |=> !err_r) else $error("err not cleared");
  a_err_w0_keep: assert property (@(posedge clk) disable iff (!reset_n)
    err_r && !(wr_status && mcu_wdata[5]) |=> err_r) else $error("err lost");
  a_err_set_nack: assert property (@(posedge clk) disable iff (!reset_n)
    pop_err |=> err_r) else $error("err not set");
  a_stop_choice: assert property (@(posedge link_clk) disable iff (!reset_n)
    state_r == iemr_pkg::ST_SHIFT && tick && phase_r == 2'd3 && bit_r == iemr_pkg::ACK_BIT
    && !is_addr_r && !(nack && !rd_byte_r)
    |=> state_r == (stop_l_r ? iemr_pkg::ST_STOP : iemr_pkg::ST_REPORT)) else $error("stop choice wrong");
  a_start_first: assert property (@(posedge link_clk) disable iff (!reset_n)
    state_r == iemr_pkg::ST_IDLE && req_s_r != req_seen_r && job_need_r
    |=> state_r == iemr_pkg::ST_START ##1 state_r == iemr_pkg::ST_START) else $error("no start");
  a_msb_first: assert property (@(posedge link_clk) disable iff (!reset_n)
    state_r == iemr_pkg::ST_SHIFT && !rd_byte_r && bit_r < iemr_pkg::ACK_BIT
    |=> sda_lvl_r == $past(shreg_r[7])) else $error("bit order wrong");
  c_rx_load: cover property (@(posedge clk) disable iff (!reset_n) load_rx);
  c_err_seen: cover property (@(posedge clk) disable iff (!reset_n) pop_err);
  c_auto_read: cover property (@(posedge clk) disable iff (!reset_n) auto_rd);
  c_fifo_stall: cover property (@(posedge clk) disable iff (!reset_n) fifo_out_valid && !fifo_out_ready);
endmodule : iemr_top
`default_nettype wire

// ---- iemr_top_tb.sv ----
// Bench for the EEPROM master: registers, write, read and error jobs
`timescale 1ns/100ps
`default_nettype none
module iemr_top_tb;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] mcu_addr = 16'h0000;
  logic mcu_wr = 1'b0, mcu_rd = 1'b0;
  logic [7:0] mcu_wdata = 8'h00, mcu_rdata, s;
  logic mcu_irq, scl_o, scl_oe_n, sda_o, sda_oe_n, ee_pull;
  // Both lines have pull-ups: high unless someone drives low
  wire scl = scl_oe_n ? 1'b1 : scl_o;
  wire sda = (sda_oe_n ? 1'b1 : sda_o) & !ee_pull;
  int n_mismatch = 0, n_compared = 0, n_irq = 0, n_stop = 0, n0, i0;
  real t0;
  always #5 clk = ~clk;
  initial begin
    #3;
    forever #24 link_clk = ~link_clk;
  end
  always @(posedge clk) if (mcu_irq === 1'b1) n_irq <= n_irq + 1;
  always @(posedge sda) if (scl === 1'b1) n_stop = n_stop + 1;
  iemr_top dut (.clk(clk), .reset_n(reset_n), .link_clk(link_clk), .mcu_addr(mcu_addr), .mcu_wr(mcu_wr),
    .mcu_rd(mcu_rd), .mcu_wdata(mcu_wdata), .mcu_rdata(mcu_rdata), .mcu_irq(mcu_irq), .scl_i(scl),
    .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
  iemr_eeprom ee (.scl(scl), .sda(sda), .sda_pull(ee_pull));
  // ****
  // Shared tasks
  // ****
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    tick();
    mcu_addr = a;
    mcu_wdata = d;
    mcu_wr = 1'b1;
    tick();
    mcu_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    tick();
    mcu_addr = a;
    mcu_rd = 1'b1;
    tick();
    mcu_rd = 1'b0;
    d = mcu_rdata;
  endtask : rd
  task automatic wait_st(input int b);
    for (int i = 0; i < 30000; i++) begin
      rd(iemr_pkg::OFS_STATUS, s);
      if (s[b] === 1'b1) break;
    end
  endtask : wait_st
  task automatic wait_stop;
    for (int i = 0; i < 60000 && n_stop == n0; i++) tick();
  endtask : wait_stop
  task automatic scl_high(input int q);
    @(posedge scl);
    t0 = $realtime;
    @(negedge scl);
    chk("scl high", 8'h01, 8'(($realtime - t0 - 2 * q * 48) ** 2 < 10 * 10));
  endtask : scl_high
  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    rd(iemr_pkg::OFS_STATUS, s);
    chk("status", 8'h04, s);
    rd(iemr_pkg::OFS_ADDR, s);
    chk("address", 8'h00, s);
    rd(iemr_pkg::OFS_RXBYTE, s);
    chk("rx byte", 8'h00, s);
    rd(16'hf0b4, s);
    chk("unmapped", 8'h00, s);
  endtask : t_reset
  task automatic t_write_slow;
    wr(iemr_pkg::OFS_STATUS, 8'h01);
    wr(iemr_pkg::OFS_ADDR, 8'ha0);
    rd(iemr_pkg::OFS_ADDR, s);
    chk("address", 8'ha0, s);
    n0 = n_stop;
    i0 = n_irq;
    wr(iemr_pkg::OFS_TXBYTE, 8'h3c);
    rd(iemr_pkg::OFS_STATUS, s);
    chk("txe busy", 8'h01, s);
    scl_high(52);
    wait_stop();
    chk("stops", 8'(n0 + 1), 8'(n_stop));
    chk("eeprom byte", 8'h3c, ee.mem);
    rd(iemr_pkg::OFS_STATUS, s);
    chk("status done", 8'h05, s);
    chk("irq", 8'h01, 8'(n_irq > i0));
    chk("bus free", 8'h03, {6'h00, scl, sda});
  endtask : t_write_slow
  task automatic t_write_hold;
    wr(iemr_pkg::OFS_STATUS, 8'h08);
    n0 = n_stop;
    wr(iemr_pkg::OFS_TXBYTE, 8'h11);
    scl_high(13);
    wait_st(iemr_pkg::BIT_TXE);
    for (int i = 0; i < 20000 && ee.mem !== 8'h11; i++) tick();
    repeat (300) tick();
    chk("no stop", 8'(n0), 8'(n_stop));
    chk("scl held", 8'h00, {7'h00, scl});
    wr(iemr_pkg::OFS_STATUS, 8'h09);
    wr(iemr_pkg::OFS_TXBYTE, 8'h77);
    wait_stop();
    chk("eeprom byte", 8'h77, ee.mem);
  endtask : t_write_hold
  task automatic t_read;
    wr(iemr_pkg::OFS_ADDR, 8'ha1);
    n0 = n_stop;
    i0 = n_irq;
    wr(iemr_pkg::OFS_TXBYTE, 8'h00);
    wait_st(iemr_pkg::BIT_RXF);
    chk("irq count", 8'h02, 8'(n_irq - i0));
    wait_stop();
    rd(iemr_pkg::OFS_RXBYTE, s);
    chk("rx byte", 8'h77, s);
    rd(iemr_pkg::OFS_STATUS, s);
    chk("status rxf", 8'h0d, s);
    wr(iemr_pkg::OFS_RXBYTE, 8'hff);
    rd(iemr_pkg::OFS_RXBYTE, s);
    chk("rx read only", 8'h77, s);
    // Two-byte read: first byte without stop, the read of it fetches the next
    wr(iemr_pkg::OFS_STATUS, 8'h08);
    wr(iemr_pkg::OFS_TXBYTE, 8'h00);
    wait_st(iemr_pkg::BIT_RXF);
    chk("scl held", 8'h00, {7'h00, scl});
    wr(iemr_pkg::OFS_STATUS, 8'h09);
    rd(iemr_pkg::OFS_RXBYTE, s);
    chk("rx first", 8'h88, s);
    wait_st(iemr_pkg::BIT_RXF);
    rd(iemr_pkg::OFS_RXBYTE, s);
    chk("rx next", 8'h99, s);
  endtask : t_read
  task automatic t_nack;
    wr(iemr_pkg::OFS_ADDR, 8'h84);
    n0 = n_stop;
    wr(iemr_pkg::OFS_TXBYTE, 8'h5a);
    wait_stop();
    wait_st(iemr_pkg::BIT_ERR);
    chk("no data", 8'haa, ee.mem);
    rd(iemr_pkg::OFS_STATUS, s);
    chk("err set", 8'h2d, s);
    wr(iemr_pkg::OFS_STATUS, 8'h09);
    rd(iemr_pkg::OFS_STATUS, s);
    chk("err kept", 8'h2d, s);
    wr(iemr_pkg::OFS_STATUS, 8'h29);
    rd(iemr_pkg::OFS_STATUS, s);
    chk("err clear", 8'h0d, s);
  endtask : t_nack
  task automatic give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  initial begin
    #900000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (20) tick();
    t_reset();
    t_write_slow();
    t_write_hold();
    t_read();
    t_nack();
    give_verdict();
  end
endmodule : iemr_top_tb
`default_nettype wire
